// file: src/remote_split_pkg.sv
// Constants for the remote index split and request tracking block
package remote_split_pkg;
   localparam int INDEX_W = 36;
   localparam int NODE_W = 12;
   localparam int OFFSET_W = 24;
   localparam int PART_MASK_W = 11;
   localparam int NODE_IDX_W = NODE_W - 1;
   localparam int CNT_W = 9;
   localparam int NUM_PROC = 2;
   localparam logic [CNT_W-1:0] THROTTLE_BIG = 9'h100;
   localparam logic [CNT_W-1:0] THROTTLE_SMALL = 9'h020;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
   localparam logic [INDEX_W-1:0] MASK_RESET = 36'h000000000;
   localparam logic [OFFSET_W-1:0] OFFSET_RESET = 24'h000000;
   localparam logic [PART_MASK_W-1:0] PART_RESET = 11'h000;
   localparam int XLATE_DEPTH = 4096;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CHECK = 3'b010,
      ST_ISSUE = 3'b100
   } split_state_t;
endpackage

// file: src/node_xlate_mem.sv
// Virtual-to-logical node translation table with registered read data
`timescale 1ns/1ps
module node_xlate_mem #(
   parameter int DEPTH = 4096,
   parameter int WIDTH = 12
) (
   // Clock
   input wire logic clk_sys,
   input wire logic clkEn,
   // Table load
   input wire logic writeEn,
   input wire logic [$clog2(DEPTH)-1:0] writeAddr,
   input wire logic [WIDTH-1:0] writeData,
   // Lookup
   input wire logic [$clog2(DEPTH)-1:0] readAddr,
   output logic [WIDTH-1:0] readData
);
   logic [WIDTH-1:0] entries [DEPTH];

   // No reset on the table itself; software loads it before virtual mode is used
   always_ff @(posedge clk_sys) begin
      if (clkEn) begin
         if (writeEn) begin
            entries[writeAddr] <= writeData;
         end
         readData <= entries[readAddr];
      end
   end
endmodule // node_xlate_mem

// file: src/remote_index_split.sv
// Remote index split, address offset check, node check and request tracking
// What this block does
// - Mask bit one: node, zero: offset
// - 36-bit index, 12 node, 24 offset
// - Mask population never checked, used as is
// - Virtual mode translates node, logical passes
// - Address offset equals base plus index offset
// - Offset above limit flags offset error
// - Offset delivered only after limit check
// - Node index drops node number LSB
// - Node index checked against partition mask
// - Count up on issue, down on response
// - Two counters, one per processor
// - Counter back to zero: transfer complete
// - Completion interrupt when enabled
// - Stall at 256 or 32 outstanding
// - Status reset code clears writer's counter
// - Any error sets error interrupt bit
`timescale 1ns/1ps
module remote_index_split
   import remote_split_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clkEn,
   // Register writes
   input wire logic maskWrite,
   input wire logic [remote_split_pkg::INDEX_W-1:0] maskData,
   input wire logic baseWrite,
   input wire logic [remote_split_pkg::OFFSET_W-1:0] baseData,
   input wire logic limitWrite,
   input wire logic [remote_split_pkg::OFFSET_W-1:0] limitData,
   input wire logic ctrlWrite,
   input wire logic ctrlVirtual,
   input wire logic ctrlSmallThrottle,
   input wire logic ctrlDoneIntEn,
   input wire logic [remote_split_pkg::PART_MASK_W-1:0] ctrlPartMask,
   input wire logic ctrlProc,
   input wire logic statusResetWrite,
   input wire logic statusResetProc,
   input wire logic indexMemError,
   // Translation table load
   input wire logic xlateWrite,
   input wire logic [remote_split_pkg::NODE_W-1:0] xlateAddr,
   input wire logic [remote_split_pkg::NODE_W-1:0] xlateData,
   // Remote index stream
   input wire logic indexValid,
   input wire logic [remote_split_pkg::INDEX_W-1:0] indexData,
   output logic indexReady,
   // Responses from support logic
   input wire logic respArrive,
   input wire logic respProc,
   // Network interface
   output logic reqValid,
   output logic [remote_split_pkg::NODE_W-1:0] reqNode,
   output logic [remote_split_pkg::OFFSET_W-1:0] reqOffset,
   output logic reqProc,
   // Status
   output logic offsetRangeError,
   output logic nodeRangeError,
   output logic errorInt,
   output logic [1:0] doneInt,
   output logic [2*remote_split_pkg::CNT_W-1:0] outstanding
);
   import remote_split_pkg::*;

   // Software-written configuration
   logic [INDEX_W-1:0] fieldMask;
   logic [OFFSET_W-1:0] remoteBase;
   logic [OFFSET_W-1:0] remoteLimit;
   logic virtualMode;
   logic smallThrottle;
   logic doneIntEn;
   logic ownerProc;
   logic [PART_MASK_W-1:0] partMask;

   split_state_t state;
   logic [NODE_W-1:0] heldNode;
   logic [OFFSET_W-1:0] heldOffset;
   logic [CNT_W-1:0] reqCount [NUM_PROC];

   // Gather the mask-selected bits into the low end of a field
   function automatic logic [INDEX_W-1:0] gatherBits(input logic [INDEX_W-1:0] val,
                                                     input logic [INDEX_W-1:0] sel);
      logic [INDEX_W-1:0] res;
      int pos;
      res = '0;
      pos = 0;
      for (int i = 0; i < INDEX_W; i++) begin
         if (sel[i]) begin
            res[pos] = val[i];
            pos++;
         end
      end
      return res;
   endfunction

   wire [INDEX_W-1:0] nodeGather = gatherBits(indexData, fieldMask);
   wire [INDEX_W-1:0] offsetGather = gatherBits(indexData, ~fieldMask);
   wire [NODE_W-1:0] nodeNumber = nodeGather[NODE_W-1:0];
   wire [OFFSET_W-1:0] indexOffset = offsetGather[OFFSET_W-1:0];
   wire [OFFSET_W-1:0] addrOffset = indexOffset + remoteBase;

   // Looked up from the held node so a new index waiting upstream cannot disturb it
   wire [NODE_W-1:0] xlateNode;
   node_xlate_mem #(.DEPTH(XLATE_DEPTH), .WIDTH(NODE_W)) xlateMem (
      .clk_sys(clk_sys),
      .clkEn(clkEn),
      .writeEn(xlateWrite),
      .writeAddr(xlateAddr),
      .writeData(xlateData),
      .readAddr(heldNode),
      .readData(xlateNode)
   );

   wire [NODE_W-1:0] finalNode = virtualMode ? xlateNode : heldNode;
   wire [NODE_IDX_W-1:0] nodeIndex = heldNode[NODE_W-1:1];
   wire nodeBad = |(nodeIndex & partMask);
   wire offsetBad = heldOffset > remoteLimit;

   wire [CNT_W-1:0] ownCount = reqCount[ownerProc];
   wire [CNT_W-1:0] throttleAt = smallThrottle ? THROTTLE_SMALL : THROTTLE_BIG;
   wire stall = ownCount >= throttleAt;
   wire issueNow = (state == ST_ISSUE) && !stall;
   wire takeIndex = (state == ST_IDLE) && indexValid;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fieldMask <= MASK_RESET;
         remoteBase <= OFFSET_RESET;
         remoteLimit <= OFFSET_RESET;
         virtualMode <= 1'b0;
         smallThrottle <= 1'b0;
         doneIntEn <= 1'b0;
         ownerProc <= 1'b0;
         partMask <= PART_RESET;
      end else if (clkEn) begin
         if (maskWrite) fieldMask <= maskData;
         if (baseWrite) remoteBase <= baseData;
         if (limitWrite) remoteLimit <= limitData;
         if (ctrlWrite) begin
            virtualMode <= ctrlVirtual;
            smallThrottle <= ctrlSmallThrottle;
            doneIntEn <= ctrlDoneIntEn;
            ownerProc <= ctrlProc;
            partMask <= ctrlPartMask;
         end
      end
   end

   // Pipeline: capture, check, then issue; the check stage gives the
   // translation table its registered read and keeps compare off the output
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         heldNode <= '0;
         heldOffset <= OFFSET_RESET;
         indexReady <= 1'b0;
         reqValid <= 1'b0;
         reqNode <= '0;
         reqOffset <= OFFSET_RESET;
         reqProc <= 1'b0;
         offsetRangeError <= 1'b0;
         nodeRangeError <= 1'b0;
      end else if (clkEn) begin
         reqValid <= 1'b0;
         indexReady <= (state == ST_IDLE) && !takeIndex;
         case (state)
            ST_IDLE: begin
               if (indexValid) begin
                  heldNode <= nodeNumber;
                  heldOffset <= addrOffset;
                  state <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               offsetRangeError <= offsetBad;
               nodeRangeError <= nodeBad;
               state <= ST_ISSUE;
            end
            ST_ISSUE: begin
               if (!stall) begin
                  reqValid <= 1'b1;
                  reqNode <= finalNode;
                  reqOffset <= heldOffset;
                  reqProc <= ownerProc;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Sticky error interrupt; set wins over clear on a control write
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         errorInt <= 1'b0;
      end else if (clkEn) begin
         if ((state == ST_CHECK && (offsetBad || nodeBad)) || indexMemError) begin
            errorInt <= 1'b1;
         end else if (ctrlWrite) begin
            errorInt <= 1'b0;
         end
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PROC; p++) begin : g_cnt
         wire inc = issueNow && (ownerProc == 1'(p));
         wire dec = respArrive && (respProc == 1'(p)) && (reqCount[p] != CNT_ZERO);
         wire clr = statusResetWrite && (statusResetProc == 1'(p));
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               reqCount[p] <= CNT_ZERO;
               doneInt[p] <= 1'b0;
            end else if (clkEn) begin
               if (clr) begin
                  reqCount[p] <= CNT_ZERO;
               end else if (inc && !dec) begin
                  reqCount[p] <= reqCount[p] + CNT_ONE;
               end else if (dec && !inc) begin
                  reqCount[p] <= reqCount[p] - CNT_ONE;
               end
               if (doneIntEn && dec && !inc && !clr && reqCount[p] == CNT_ONE) begin
                  doneInt[p] <= 1'b1;
               end else if (clr || inc) begin
                  doneInt[p] <= 1'b0;
               end
            end
         end
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               outstanding[p*CNT_W +: CNT_W] <= CNT_ZERO;
            end else if (clkEn) begin
               outstanding[p*CNT_W +: CNT_W] <= reqCount[p];
            end
         end
      end
   endgenerate

   // The range flags must be settled before the request leaves
   AST_OFFSET_ORDER: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && state == ST_CHECK && offsetBad) |=> offsetRangeError)
      else $error("offset error not flagged before issue");
   AST_STALL: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && state == ST_ISSUE && ownCount >= throttleAt) |=> !reqValid)
      else $error("request issued at throttle limit");
   AST_ERR_INT: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && (nodeRangeError || offsetRangeError) && $rose(state == ST_ISSUE)) |-> errorInt)
      else $error("error interrupt missing");
   AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && statusResetWrite && statusResetProc == 1'b1) |=> reqCount[1] == CNT_ZERO)
      else $error("counter not cleared");
   AST_CLEAR_OTHER: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && statusResetWrite && statusResetProc == 1'b1 && !(issueNow && !ownerProc)
       && !(respArrive && !respProc)) |=> reqCount[0] == $past(reqCount[0]))
      else $error("reset code disturbed the other counter");
   AST_NODE_RANGE: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && state == ST_CHECK) |=> nodeRangeError == |($past(heldNode[NODE_W-1:1]) & partMask))
      else $error("node range error wrong");
   AST_LIMIT: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && state == ST_CHECK && heldOffset <= remoteLimit) |=> !offsetRangeError)
      else $error("false offset error");
   AST_COUNT_UP: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && issueNow && ownerProc == 1'b0 && !respArrive && !statusResetWrite)
      |=> reqCount[0] == $past(reqCount[0]) + CNT_ONE)
      else $error("counter did not increment");
   AST_DONE: assert property (@(posedge clk_sys) disable iff (!rstn)
      (clkEn && doneIntEn && respArrive && respProc == 1'b1 && reqCount[1] == CNT_ONE
       && !(issueNow && ownerProc) && !statusResetWrite) |=> doneInt[1])
      else $error("completion interrupt missing");
endmodule // remote_index_split

// file: verification/net_resp_model.sv
// Far-side model: queues issued requests and returns one response each
`timescale 1ns/1ps
module net_resp_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Pacing
   input wire logic go,
   input wire logic slow,
   // Requests seen, responses returned
   input wire logic reqValid,
   input wire logic reqProc,
   output logic respArrive,
   output logic respProc
);
   bit q[$];
   int waitN = 0;
   initial respArrive = 1'b0;
   initial respProc = 1'b0;
   // one response per request, tagged with its processor
   always @(negedge clk_sys) begin
      respArrive <= 1'b0;
      // Stale owner would hide a wrong decode, so it toggles between answers
      respProc <= ~respProc;
      if (!rstn) begin
         q.delete();
      end else if (waitN > 0) begin
         waitN--;
      end else if (go && q.size() > 0) begin
         respArrive <= 1'b1;
         respProc <= q.pop_front();
         waitN = slow ? 7 : 1;
      end
   end
   always @(posedge clk_sys) if (rstn && reqValid) q.push_back(reqProc);
endmodule // net_resp_model

// file: verification/remote_index_split_tb.sv
// Self-checking bench for the remote index split and request tracking block
`timescale 1ns/1ps
module remote_index_split_tb;
   import remote_split_pkg::*;
   logic clk_sys = 0, rstn = 0, maskWrite = 0, baseWrite = 0, limitWrite = 0, ctrlWrite = 0;
   logic ctrlVirtual = 0, ctrlSmallThrottle = 0, ctrlDoneIntEn = 0, ctrlProc = 0;
   logic statusResetWrite = 0, statusResetProc = 0, indexMemError = 0, xlateWrite = 0;
   logic indexValid = 0, indexReady, respArrive, respProc, reqValid, reqProc;
   logic offsetRangeError, nodeRangeError, errorInt, go = 0, slow = 0, clkEn = 1;
   logic [35:0] maskData = 0, indexData = 0, mask, lastIdx;
   logic [23:0] baseData = 0, limitData = 0, reqOffset, base, lim;
   logic [10:0] ctrlPartMask = 0, pm;
   logic [11:0] xlateAddr = 0, xlateData = 0, reqNode, xt[int];
   logic [1:0] doneInt;
   logic [17:0] outstanding;
   int cnt[2], err_count = 0, total_checks = 0;
   bit dn[2], errM, virt, en, own, got;
   remote_index_split dut_u (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
      .maskWrite(maskWrite), .maskData(maskData), .baseWrite(baseWrite), .baseData(baseData),
      .limitWrite(limitWrite), .limitData(limitData), .ctrlWrite(ctrlWrite),
      .ctrlVirtual(ctrlVirtual), .ctrlSmallThrottle(ctrlSmallThrottle),
      .ctrlDoneIntEn(ctrlDoneIntEn), .ctrlPartMask(ctrlPartMask), .ctrlProc(ctrlProc),
      .statusResetWrite(statusResetWrite), .statusResetProc(statusResetProc),
      .indexMemError(indexMemError), .xlateWrite(xlateWrite), .xlateAddr(xlateAddr),
      .xlateData(xlateData), .indexValid(indexValid), .indexData(indexData),
      .indexReady(indexReady), .respArrive(respArrive), .respProc(respProc),
      .reqValid(reqValid), .reqNode(reqNode), .reqOffset(reqOffset), .reqProc(reqProc),
      .offsetRangeError(offsetRangeError), .nodeRangeError(nodeRangeError),
      .errorInt(errorInt), .doneInt(doneInt), .outstanding(outstanding));
   net_resp_model resp_u (.clk_sys(clk_sys), .rstn(rstn), .go(go), .slow(slow),
      .reqValid(reqValid), .reqProc(reqProc), .respArrive(respArrive), .respProc(respProc));
   always #2.5 clk_sys = ~clk_sys;
   // Counter model follows the responses that the far-side model hands back
   always @(posedge clk_sys) begin
      if (respArrive && cnt[respProc] > 0) begin
         cnt[respProc]--;
         if (cnt[respProc] == 0 && en) dn[respProc] = 1;
      end
   end
   task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Extra mask bits past twelve or twenty-four fall off the top
   function automatic void split(input logic [35:0] x, output logic [11:0] nd,
                                 output logic [23:0] of);
      int a = 0;
      int b = 0;
      nd = '0;
      of = '0;
      for (int i = 0; i < 36; i++) begin
         if (mask[i]) begin
            if (a < 12) nd[a] = x[i];
            a++;
         end else begin
            if (b < 24) of[b] = x[i];
            b++;
         end
      end
   endfunction
   task automatic regs(input logic [35:0] m, input logic [23:0] b, input logic [23:0] l);
      mask = m;
      base = b;
      lim = l;
      {maskData, baseData, limitData} = {m, b, l};
      {maskWrite, baseWrite, limitWrite} = 3'b111;
      @(negedge clk_sys) {maskWrite, baseWrite, limitWrite} = 3'b000;
   endtask
   task automatic ctrl(input bit v, input bit sm, input logic [10:0] p, input bit o);
      {virt, pm, own, en, errM} = {v, p, o, 1'b1, 1'b0};
      {ctrlVirtual, ctrlSmallThrottle, ctrlDoneIntEn, ctrlPartMask, ctrlProc} = {v, sm, 1'b1, p, o};
      ctrlWrite = 1;
      @(negedge clk_sys) ctrlWrite = 0;
   endtask
   task automatic offer(input logic [35:0] x);
      for (int i = 0; i < 400 && indexReady !== 1'b1; i++) @(negedge clk_sys);
      chk("indexReady", indexReady, 1'b1);
      lastIdx = x;
      indexData = x;
      indexValid = 1;
      @(negedge clk_sys) indexValid = 0;
   endtask
   task automatic result(input int n);
      logic [11:0] nd;
      logic [23:0] of, ad;
      got = 0;
      for (int i = 0; i < n && !got; i++) begin
         if (reqValid === 1'b1) got = 1;
         else @(negedge clk_sys);
      end
      if (got) begin
         split(lastIdx, nd, of);
         ad = base + of;
         errM |= (ad > lim) || ((nd[11:1] & pm) != 0);
         cnt[own]++;
         dn[own] = 0;
         chk("reqNode", reqNode, virt ? xt[nd] : nd);
         chk("reqOffset", reqOffset, ad);
         chk("offsetRangeError", offsetRangeError, ad > lim);
         chk("nodeRangeError", nodeRangeError, (nd[11:1] & pm) != 0);
         chk("reqProc", reqProc, own);
         chk("errorInt", errorInt, errM);
         @(negedge clk_sys);
         chk("reqValidPulse", reqValid, 1'b0);
      end
   endtask
   task automatic counts();
      chk("outstanding", outstanding, {9'(cnt[1]), 9'(cnt[0])});
      chk("doneInt", doneInt, {dn[1], dn[0]});
   endtask
   initial begin
      #100us;
      err_count++;
      end_sim();
   end
   initial begin
      logic [11:0] nd;
      logic [23:0] of;
      logic [35:0] x;
      void'($urandom(32'h2218fc26));
      repeat (3) @(negedge clk_sys);
      rstn = 1;
      go = 1;
      for (int i = 0; i < 24; i++) begin
         if (i % 6 == 0) begin
            // twelve node bits; one mask with only eight exercises
            x = 0;
            while ($countones(x) < (i == 18 ? 8 : 12)) x[$urandom_range(35, 0)] = 1;
            regs(x, $urandom, $urandom);
            ctrl(0, 0, (i == 0) ? 11'h000 : 11'h7f0 << $urandom_range(3, 0), $urandom);
         end
         slow = $urandom;
         offer(36'({$urandom, $urandom}));
         result(200);
      end
      $display("split and range test done");
      ctrl(1, 0, 11'h000, 1);
      for (int i = 0; i < 8; i++) begin
         x = 36'({$urandom, $urandom});
         split(x, nd, of);
         xt[nd] = 12'($urandom);
         {xlateAddr, xlateData, xlateWrite} = {nd, xt[nd], 1'b1};
         @(negedge clk_sys) xlateWrite = 0;
         offer(x);
         result(200);
      end
      repeat (600) @(negedge clk_sys);
      counts();
      $display("virtual mode test done");
      go = 0;
      // logical mode with the partition mask cleared
      ctrl(0, 1, 11'h000, 0);
      for (int i = 0; i < 32; i++) begin
         offer(36'({$urandom, $urandom}));
         result(200);
      end
      offer(36'h0);
      result(30);
      chk("stalledAt32", got, 0);
      go = 1;
      result(400);
      chk("resumedAfterResponse", got, 1);
      repeat (600) @(negedge clk_sys);
      counts();
      $display("throttle test done");
      go = 0;
      for (int i = 0; i < 5; i++) begin
         if (i == 0 || i == 3) ctrl(0, 0, 11'h000, i == 3);
         offer(36'($urandom));
         result(200);
      end
      // With the enable low the reset code must not take effect yet
      clkEn = 0;
      {statusResetProc, statusResetWrite} = 2'b11;
      repeat (3) @(negedge clk_sys);
      counts();
      clkEn = 1;
      cnt[1] = 0;
      @(negedge clk_sys) statusResetWrite = 0;
      repeat (3) @(negedge clk_sys);
      counts();
      indexMemError = 1;
      @(negedge clk_sys) indexMemError = 0;
      @(negedge clk_sys);
      chk("errorIntMem", errorInt, 1);
      go = 1;
      repeat (200) @(negedge clk_sys);
      counts();
      $display("counter reset test done");
      end_sim();
   end
endmodule // remote_index_split_tb
